/* File: hdl/smw_ctrl.sv */
// Purpose : reset release, stop-mode entry/exit and wake-up timer control
// Assumes : wake sources are levels or pulses from pins or other domains
// Notes   : every output registered; reset beats any wake
// Notes on behaviour
// - hold whole chip reset while pin low
// - on release, fetch starts at 8000h
// - stop mode entered only by software request
// - stop halts CPU, keeps state and memories
// - four wake sources end stop mode
// - timer ticks from ring oscillator, runs in stop
// - timer interval in 125 us steps, ~8 s
// - I2C wake only on factory address match
`timescale 1ns/1ps
module smw_ctrl
    import smw_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ext_reset_low_in,
    input  wire logic        i_ring_clk,
    input  wire logic        i_stop_req,
    input  wire logic [15:0] i_wake_steps,
    input  wire logic        i_i2c_addr_valid,
    input  wire logic [6:0]  i_i2c_addr,
    input  wire logic        i_ext_irq,
    input  wire logic        i_pfw_irq,
    input  wire logic        i_pf_reset,
    output logic             o_cpu_reset,
    output logic             o_cpu_halt,
    output logic             o_fetch_load,
    output logic [15:0]      o_fetch_addr,
    output logic             o_stop_active,
    output logic             o_wake_pulse
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] raw, s1_q, s2_q;
    assign raw = {i_ext_reset_low_in,
                  i_ring_clk,
                  i_ext_irq,
                  i_pfw_irq,
                  i_pf_reset};
    // sync flops clear low, so after i_srst the pin
    // reads as reset for two cycles before boot starts

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge i_sys_clk)
            begin
                if (i_srst)
                begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end
                else
                begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    logic rst_n_s;
    logic ring_s;
    logic eirq_s;
    logic pfw_s;
    logic pfr_s;
    assign {rst_n_s, ring_s, eirq_s, pfw_s, pfr_s} = s2_q;

    // ------------------------------------------------------------------
    // ring edge to tick, state
    // ------------------------------------------------------------------
    smw_wake_if wk ();

    smw_state_type st_q,   st_d;
    logic          ring_q, ring_d;
    logic [15:0]   lim_q,  lim_d;
    // boot vector kept in a flop so every output is registered
    logic [15:0]   fa_q,   fa_d;
    logic          rst_q,  rst_d;
    logic          halt_q, halt_d;
    logic          ld_q,   ld_d;
    logic          stop_q, stop_d;
    logic          wake_q, wake_d;
    logic          tick;
    logic          wake_any;
    logic          addr_hit;

    // ------------------------------------------------------------------
    // address decode and wake sources
    // ------------------------------------------------------------------
    function automatic logic addr_match(input logic [6:0] a);
        return a == SLAVE_ADDR;
    endfunction

    // a ring pin already high at reset gives one stray
    // tick; harmless, the timer is disarmed until stop
    assign tick     = ring_s & ~ring_q;
    assign addr_hit = i_i2c_addr_valid & addr_match(i_i2c_addr);
    // power-fail reset is left out: it takes the reset path
    assign wake_any = addr_hit | eirq_s | pfw_s | wk.expired;
    assign wk.arm   = (st_q == ST_STOP);
    // limit latched at stop entry; zero leaves the timer off
    assign wk.limit = lim_q;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d   = st_q;
        ring_d = ring_s;
        lim_d  = lim_q;
        fa_d   = BOOT_ADDR;
        rst_d  = 1'b0;
        halt_d = 1'b0;
        ld_d   = 1'b0;
        stop_d = 1'b0;
        wake_d = 1'b0;
        if (!rst_n_s || pfr_s)
        begin
            // power-fail reset also ends stop through full reset
            st_d  = ST_RESET;
            rst_d = 1'b1;
        end
        else
        begin
            case (st_q)
                ST_RESET:
                begin
                    st_d = ST_RUN;
                    ld_d = 1'b1;
                end
                ST_RUN:
                begin
                    if (i_stop_req)
                    begin
                        st_d   = ST_STOP;
                        lim_d  = i_wake_steps;
                        halt_d = 1'b1;
                        stop_d = 1'b1;
                    end
                end
                ST_STOP:
                begin
                    if (wake_any)
                    begin
                        st_d   = ST_RUN;
                        wake_d = 1'b1;
                    end
                    else
                    begin
                        halt_d = 1'b1;
                        stop_d = 1'b1;
                    end
                end
                default:
                begin
                    st_d  = ST_RESET;
                    rst_d = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            st_q   <= ST_RESET;
            ring_q <= 1'b0;
            lim_q  <= TIMER_RST;
            fa_q   <= BOOT_ADDR;
            rst_q  <= 1'b1;
            halt_q <= 1'b0;
            ld_q   <= 1'b0;
            stop_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            ring_q <= ring_d;
            lim_q  <= lim_d;
            fa_q   <= fa_d;
            rst_q  <= rst_d;
            halt_q <= halt_d;
            ld_q   <= ld_d;
            stop_q <= stop_d;
            wake_q <= wake_d;
        end
    end

    // ------------------------------------------------------------------
    // wake-up timer
    // ------------------------------------------------------------------
    smw_wake_timer u_timer (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_tick    (tick),
        .wk        (wk)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_cpu_reset   = rst_q;
    assign o_cpu_halt    = halt_q;
    assign o_fetch_load  = ld_q;
    assign o_fetch_addr  = fa_q;
    assign o_stop_active = stop_q;
    assign o_wake_pulse  = wake_q;
endmodule // smw_ctrl

/* File: hdl/smw_pkg.sv */
// Purpose : shared constants and types for the stop/wake/reset controller
// Assumes : 125 MHz system clock, 8 kHz ring oscillator tick from outside
// Notes   : all counts derived from printed times
package smw_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          TICK_PERIOD_NS = 125000;   // 125 us step
    localparam int          TIMER_W        = 16;       // 65535 steps ~ 8 s
    localparam logic [15:0] BOOT_ADDR      = 16'h8000;
    localparam logic [15:0] TIMER_RST      = 16'h0000;
    localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h2a;    // arbitrary value

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01,
        ST_STOP  = 2'b10
    } smw_state_type;

endpackage : smw_pkg

/* File: hdl/smw_wake_if.sv */
// Purpose : carries wake-up timer events between timer and controller
// Assumes : single clock domain
// Notes   : none
`timescale 1ns/1ps
interface smw_wake_if;
    logic        arm;
    logic [15:0] limit;
    logic        expired;
    modport ctrl  (output arm, output limit, input expired);
    modport timer (input arm, input limit, output expired);
endinterface : smw_wake_if

/* File: hdl/smw_wake_timer.sv */
// Purpose : wake-up timer counting ring-oscillator ticks
// Assumes : i_tick already synchronised, one cycle per rising ring edge
// Notes   : count restarts whenever arm drops
`timescale 1ns/1ps
module smw_wake_timer
    import smw_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_tick,
    smw_wake_if.timer wk
);
    logic [TIMER_W-1:0] cnt_q, cnt_d;
    logic               exp_q, exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (!wk.arm)
        begin
            cnt_d = TIMER_RST;
        end
        else if (i_tick)
        begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_d == wk.limit && wk.limit != 16'h0000)
            begin
                exp_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            cnt_q <= TIMER_RST;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign wk.expired = exp_q;
endmodule // smw_wake_timer

/* File: testbench/smw_ctrl_monitor.sv */
// Purpose: port checks for the stop/wake/reset controller
// Assumes: async inputs take two sync flops plus one register
// Notes: bind after the module
`timescale 1ns/1ps
module smw_ctrl_monitor
#(
    parameter logic [6:0] SLAVE_ADDR = smw_pkg::SLAVE_ADDR_DEF
)
(
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_ext_reset_low_in,
    input wire logic        i_stop_req,
    input wire logic        i_i2c_addr_valid,
    input wire logic [6:0]  i_i2c_addr,
    input wire logic        i_pf_reset,
    input wire logic        o_cpu_reset,
    input wire logic        o_cpu_halt,
    input wire logic        o_fetch_load,
    input wire logic [15:0] o_fetch_addr,
    input wire logic        o_stop_active,
    input wire logic        o_wake_pulse
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_boot_addr_fixed: assert property (o_fetch_addr == 16'h8000)
        else $error("fetch address is not the boot address");
    a_pin_holds_reset: assert property
        (!i_ext_reset_low_in [*3] |=> o_cpu_reset)
        else $error("low pin did not hold reset");
    a_load_ends_reset: assert property
        (o_fetch_load |-> $past(o_cpu_reset) && !o_cpu_reset)
        else $error("fetch load without reset release");
    a_stop_on_request: assert property
        (i_stop_req && !o_cpu_reset && !o_stop_active && !o_wake_pulse
         && !o_fetch_load && !i_pf_reset && i_ext_reset_low_in
         |=> o_stop_active)
        else $error("stop request not taken");
    a_stop_needs_cause: assert property
        ($rose(o_stop_active) |-> $past(i_stop_req))
        else $error("stop entered without request");
    a_halt_with_stop: assert property (o_cpu_halt == o_stop_active)
        else $error("halt and stop disagree");
    a_wake_leaves_stop: assert property
        (o_wake_pulse |-> $past(o_stop_active) && !o_stop_active)
        else $error("wake pulse without stop exit");
    a_addr_match_wakes: assert property
        (o_stop_active && i_i2c_addr_valid && i_i2c_addr == SLAVE_ADDR
         |-> ##[1:2] o_wake_pulse)
        else $error("matching address did not wake");
    a_pf_forces_reset: assert property
        (i_pf_reset [*3] |=> o_cpu_reset)
        else $error("power-fail reset not applied");
endmodule // smw_ctrl_monitor

bind smw_ctrl smw_ctrl_monitor #(.SLAVE_ADDR(SLAVE_ADDR)) i_mon (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_ext_reset_low_in(i_ext_reset_low_in), .i_stop_req(i_stop_req),
    .i_i2c_addr_valid(i_i2c_addr_valid), .i_i2c_addr(i_i2c_addr),
    .i_pf_reset(i_pf_reset), .o_cpu_reset(o_cpu_reset),
    .o_cpu_halt(o_cpu_halt), .o_fetch_load(o_fetch_load),
    .o_fetch_addr(o_fetch_addr), .o_stop_active(o_stop_active),
    .o_wake_pulse(o_wake_pulse));

/* File: testbench/smw_ctrl_tb.sv */
// Purpose: self-checking bench for the stop/wake/reset controller
// Assumes: inputs change on the falling edge
// Notes: timer case waits two real ring ticks
`timescale 1ns/1ps
module smw_ctrl_tb;
    import smw_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, pull = 1'b0, stp = 1'b0;
    logic        av = 1'b0, ext = 1'b0, pfw = 1'b0, pfr = 1'b0;
    logic [15:0] wsteps = 16'h0000;
    logic [6:0]  addr = 7'h00;
    logic        ring, pin, cr, ch, ld, sa, wk;
    logic [15:0] fa;
    int          n_fail = 0, num_checks = 0, ticks = 0;
    always #4 clk = ~clk;
    always @(posedge ring) ticks++;
    smw_src_model i_smw_src_model (.i_pull_low(pull), .o_ring_clk(ring),
        .o_reset_pin(pin));
    smw_ctrl i_smw_ctrl (.i_sys_clk(clk), .i_srst(srst),
        .i_ext_reset_low_in(pin), .i_ring_clk(ring), .i_stop_req(stp),
        .i_wake_steps(wsteps), .i_i2c_addr_valid(av), .i_i2c_addr(addr),
        .i_ext_irq(ext), .i_pfw_irq(pfw), .i_pf_reset(pfr),
        .o_cpu_reset(cr), .o_cpu_halt(ch), .o_fetch_load(ld),
        .o_fetch_addr(fa), .o_stop_active(sa), .o_wake_pulse(wk));
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_hi(string nm, int lim, bit on_load);
        int k;
        k = 0;
        while ((on_load ? ld : wk) !== 1'b1 && k < lim)
        begin
            cyc(1);
            k++;
        end
        chk(nm, on_load ? ld : wk, 16'h0001);
    endtask
    task automatic go_stop(logic [15:0] s);
        stp = 1'b1;
        wsteps = s;
        cyc(1);
        stp = 1'b0;
        cyc(1);
        chk("stop", sa, 1);
        chk("halt", ch, 1);
    endtask
    task automatic t_pin;
        pull = 1'b1;
        cyc(4);
        chk("reset", cr, 1);
        cyc(20);
        chk("reset", cr, 1);
        pull = 1'b0;
        wait_hi("load", 20, 1);
        chk("fetch", fa, BOOT_ADDR);
        chk("reset", cr, 16'h0000);
        $display("pin reset test done");
    endtask
    task automatic t_wake;
        for (int s = 0; s < 3; s++)
        begin
            go_stop(16'h0000);
            addr = SLAVE_ADDR_DEF ^ 7'h01;
            av = (s == 0);
            cyc(1);
            av = 1'b0;
            cyc(4);
            chk("stop", sa, 1);
            addr = SLAVE_ADDR_DEF;
            av = (s == 0);
            ext = (s == 1);
            pfw = (s == 2);
            cyc(1);
            av = 1'b0;
            wait_hi("wake", 8, 0);
            chk("stop", sa, 0);
            cyc(1);
            chk("wake", wk, 16'h0000);
            chk("halt", ch, 16'h0000);
            ext = 1'b0;
            pfw = 1'b0;
            cyc(4);
        end
        $display("wake source test done");
    endtask
    task automatic t_pf;
        go_stop(16'h0000);
        pfr = 1'b1;
        cyc(4);
        chk("reset", cr, 1);
        pfr = 1'b0;
        wait_hi("load", 20, 1);
        $display("power-fail test done");
    endtask
    task automatic t_timer;
        @(posedge ring);
        cyc(10);
        ticks = 0;
        go_stop(16'h0002);
        wait_hi("wake", 40000, 0);
        chk("ticks", 16'(ticks), 16'h0002);
        $display("timer test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        srst = 1'b0;
        wait_hi("load", 20, 1);
        chk("fetch", fa, BOOT_ADDR);
        t_pin;
        t_wake;
        t_pf;
        t_timer;
        report_and_stop;
    end
    initial
    begin
        #500000;
        n_fail++;
        report_and_stop;
    end
endmodule // smw_ctrl_tb

/* File: testbench/smw_src_model.sv */
// Purpose: ring oscillator and external reset source
// Assumes: ring runs free, also in stop
// Notes: pin has a pull-up, so released reads high
`timescale 1ns/1ps
module smw_src_model
(
    input  wire logic i_pull_low,
    output logic      o_ring_clk,
    output wire logic o_reset_pin
);
    // half-ns offset keeps ring edges off the system clock edges
    initial
    begin
        o_ring_clk = 1'b0;
        #0.5;
        forever #62500 o_ring_clk = ~o_ring_clk; // 125 us tick
    end
    assign o_reset_pin = i_pull_low ? 1'b0 : 1'b1; // pull-up
endmodule // smw_src_model
